// File: core/pcs_top.v
// Functional notes
// - Count checker packets in 32 bits, two halves
// - Control bit 15 or 14 freezes packet count
// - Single mode stops packet counter at all-ones
// - Set finished bit 12 after generator completes
// - Show generator active at status bit 11
// - Packet overflow flag bit 10, cleared by bit 15
// - Byte overflow flag bit 9, cleared by bit 15
// - Eight-bit error tally, frozen by bit 0/1
// - Single mode stops error tally at 0xff
// - Bit 0 locks packet count and tally, bit 1 locks and clears
// - 32-bit error byte counter, cleared by 15/14
// - Continuous mode pulses at max, restarts from zero
`timescale 1ns/1ps
`include "pcs_consts.vh"

module pcs_top #(
    parameter AW  = `PCS_ADDR_W,
    parameter DW  = `PCS_DATA_W,
    parameter PKT_W  = 32,
    parameter ERR_W  = 32,
    parameter BYTE_W = 16,
    parameter TAL_W  = 8
) (
    // Clock, enable and reset
    input  wire          core_clk,
    input  wire          ce,
    input  wire          rst,
    // Register port
    input  wire [AW-1:0] regAddr,
    input  wire [DW-1:0] regWdata,
    input  wire          regWr,
    input  wire          regRd,
    output wire [DW-1:0] regRdata,
    // Checker events
    input  wire          chkPktRx,
    input  wire          chkByteRx,
    input  wire          chkByteErr,
    input  wire          chkLock,
    // Generator status
    input  wire          genBusy,
    input  wire          genDone,
    // Outputs
    output wire          irq,
    output wire          counterWrap
);
    reg  [DW-1:0]        rdata_q;
    reg  [DW-1:0]        rdata_d;
    reg                  contMode_q;
    reg                  pktOv_q;
    reg                  byteOv_q;
    reg                  done_q;
    reg                  busy_q;
    reg                  lock_q;
    reg                  wrap_q;

    wire                 ctrlWr;
    wire                 lockAll;
    wire                 clrAll;
    wire                 clrErr;
    wire                 statWr;
    wire                 maskWr;
    wire                 irqLine;

    wire [PKT_W-1:0]     pktSnap;
    wire [ERR_W-1:0]     errCount;
    wire [PKT_W+31:0]    pktSnapPad;
    wire [ERR_W+31:0]    errCountPad;
    wire [31:0]          pktSnapWin;
    wire [31:0]          errCountWin;
    wire [TAL_W-1:0]     tallySnap;
    wire                 pktWrap;
    wire                 errWrap;
    wire                 byteWrap;
    wire                 tallyWrap;
    wire                 pktOvEv;
    wire                 byteOvEv;
    wire                 tallyOvEv;
    wire [`PCS_IRQ_N-1:0] irqEvents;
    wire [`PCS_IRQ_N-1:0] irqStatus;
    wire [`PCS_IRQ_N-1:0] irqMask;
    wire [DW-1:0]        flagsWord;

    function [DW-1:0] pickHalf;
        input [31:0] value;
        input        high;
        begin
            pickHalf = high ? value[31:16] : value[15:0];
        end
    endfunction

    function isAddr;
        input [AW-1:0] a;
        input [AW-1:0] off;
        begin
            isAddr = (a == off);
        end
    endfunction

    assign regRdata    = rdata_q;
    assign irq         = irqLine;
    assign counterWrap = wrap_q;

    // Counter widths up to 32 bits meet the fixed 32-bit read window
    assign pktSnapPad  = {32'h00000000, pktSnap};
    assign pktSnapWin  = pktSnapPad[31:0];
    assign errCountPad = {32'h00000000, errCount};
    assign errCountWin = errCountPad[31:0];

    // Control triggers act only on bits written as one
    assign ctrlWr  = regWr & isAddr(regAddr, `PCS_OFF_CTRL);
    assign lockAll = ctrlWr & (regWdata[`PCS_CTRL_LOCK] | regWdata[`PCS_CTRL_LOCK_CLR]
                     | regWdata[`PCS_CTRL_PKT_LOCK] | regWdata[`PCS_CTRL_CLR_ALL]);
    assign clrAll  = ctrlWr & (regWdata[`PCS_CTRL_LOCK_CLR]
                     | regWdata[`PCS_CTRL_CLR_ALL]);
    assign clrErr  = ctrlWr & (regWdata[`PCS_CTRL_PKT_LOCK]
                     | regWdata[`PCS_CTRL_CLR_ALL] | regWdata[`PCS_CTRL_LOCK_CLR]);
    assign statWr  = regWr & isAddr(regAddr, `PCS_OFF_IRQ_STAT);
    assign maskWr  = regWr & isAddr(regAddr, `PCS_OFF_IRQ_MASK);

    // Received packet counter, readable through its snapshot
    pcs_counter #(
        .W          (PKT_W)
    ) u_pkt (
        .core_clk   (core_clk),
        .ce         (ce),
        .rst        (rst),
        .inc        (chkPktRx),
        .clr        (clrAll),
        .lock       (lockAll),
        .contMode   (contMode_q),
        .count      (),
        .snap       (pktSnap),
        .wrapPulse  (pktWrap),
        .ovEvent    (pktOvEv)
    );

    // Errored byte counter, read live
    pcs_counter #(
        .W          (ERR_W)
    ) u_err (
        .core_clk   (core_clk),
        .ce         (ce),
        .rst        (rst),
        .inc        (chkByteErr),
        .clr        (clrErr),
        .lock       (1'b0),
        .contMode   (contMode_q),
        .count      (errCount),
        .snap       (),
        .wrapPulse  (errWrap),
        .ovEvent    ()
    );

    // Received byte counter; only its overflow is visible here
    pcs_counter #(
        .W          (BYTE_W)
    ) u_byte (
        .core_clk   (core_clk),
        .ce         (ce),
        .rst        (rst),
        .inc        (chkByteRx),
        .clr        (clrAll),
        .lock       (1'b0),
        .contMode   (contMode_q),
        .count      (),
        .snap       (),
        .wrapPulse  (byteWrap),
        .ovEvent    (byteOvEv)
    );

    // Errored byte tally
    pcs_counter #(
        .W          (TAL_W)
    ) u_tally (
        .core_clk   (core_clk),
        .ce         (ce),
        .rst        (rst),
        .inc        (chkByteErr),
        .clr        (clrAll),
        .lock       (lockAll),
        .contMode   (contMode_q),
        .count      (),
        .snap       (tallySnap),
        .wrapPulse  (tallyWrap),
        .ovEvent    (tallyOvEv)
    );

    assign irqEvents = {(pktWrap | errWrap | byteWrap | tallyWrap),
                        tallyOvEv, byteOvEv, pktOvEv, genDone};

    pcs_irq #(
        .N          (`PCS_IRQ_N)
    ) u_irq (
        .core_clk   (core_clk),
        .ce         (ce),
        .rst        (rst),
        .events     (irqEvents),
        .statWr     (statWr),
        .maskWr     (maskWr),
        .wdata      (regWdata[`PCS_IRQ_N-1:0]),
        .status     (irqStatus),
        .mask       (irqMask),
        .irq        (irqLine)
    );

    // Status flags; clrAll wins over a same-cycle overflow event, genDone over a run start
    always @(posedge core_clk) begin
        if (rst) begin
            pktOv_q  <= 1'b0;
            byteOv_q <= 1'b0;
            done_q   <= 1'b0;
            busy_q   <= 1'b0;
            lock_q   <= 1'b0;
            wrap_q   <= 1'b0;
        end else if (ce) begin
            if (pktOvEv) begin
                pktOv_q <= 1'b1;
            end else if (clrAll) begin
                pktOv_q <= 1'b0;
            end
            if (byteOvEv) begin
                byteOv_q <= 1'b1;
            end else if (clrAll) begin
                byteOv_q <= 1'b0;
            end
            // Finished stays until the generator starts a new run
            if (genDone) begin
                done_q <= 1'b1;
            end else if (genBusy && !busy_q) begin
                done_q <= 1'b0;
            end
            busy_q <= genBusy;
            lock_q <= chkLock;
            wrap_q <= pktWrap | errWrap | byteWrap | tallyWrap;
        end
    end

    // Configuration register
    always @(posedge core_clk) begin
        if (rst) begin
            contMode_q <= `PCS_RST_CFG;
        end else if (ce) begin
            if (regWr && isAddr(regAddr, `PCS_OFF_CFG)) begin
                contMode_q <= regWdata[`PCS_CFG_CONT];
            end
        end
    end

    assign flagsWord = {3'h0, done_q, busy_q, pktOv_q, byteOv_q, lock_q, tallySnap};

    // Read decode; writes to counter and flag offsets have no effect
    always @* begin
        rdata_d = `PCS_RST_REG;
        if (isAddr(regAddr, `PCS_OFF_PKT_LO)) begin
            rdata_d = pickHalf(pktSnapWin, 1'b0);
        end else if (isAddr(regAddr, `PCS_OFF_PKT_HI)) begin
            rdata_d = pickHalf(pktSnapWin, 1'b1);
        end else if (isAddr(regAddr, `PCS_OFF_FLAGS)) begin
            rdata_d = flagsWord;
        end else if (isAddr(regAddr, `PCS_OFF_ERR_LO)) begin
            rdata_d = pickHalf(errCountWin, 1'b0);
        end else if (isAddr(regAddr, `PCS_OFF_ERR_HI)) begin
            rdata_d = pickHalf(errCountWin, 1'b1);
        end else if (isAddr(regAddr, `PCS_OFF_CFG)) begin
            rdata_d = {15'h0000, contMode_q};
        end else if (isAddr(regAddr, `PCS_OFF_IRQ_STAT)) begin
            rdata_d = {11'h000, irqStatus};
        end else if (isAddr(regAddr, `PCS_OFF_IRQ_MASK)) begin
            rdata_d = {11'h000, irqMask};
        end
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= `PCS_RST_REG;
        end else if (ce) begin
            rdata_q <= regRd ? rdata_d : `PCS_RST_REG;
        end
    end
endmodule

// File: core/pcs_consts.vh
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// Bus geometry
`define PCS_ADDR_W          12
`define PCS_DATA_W          16

// Register offsets
`define PCS_OFF_CTRL        12'h01b
`define PCS_OFF_PKT_LO      12'h61d
`define PCS_OFF_PKT_HI      12'h61e
`define PCS_OFF_FLAGS       12'h620
`define PCS_OFF_ERR_LO      12'h622
`define PCS_OFF_ERR_HI      12'h623
`define PCS_OFF_CFG         12'h630
`define PCS_OFF_IRQ_STAT    12'h631
`define PCS_OFF_IRQ_MASK    12'h632

// Control register trigger bits
`define PCS_CTRL_LOCK       0
`define PCS_CTRL_LOCK_CLR   1
`define PCS_CTRL_PKT_LOCK   14
`define PCS_CTRL_CLR_ALL    15

// Flags register fields
`define PCS_FLG_DONE        12
`define PCS_FLG_BUSY        11
`define PCS_FLG_PKT_OV      10
`define PCS_FLG_BYTE_OV     9
`define PCS_FLG_LOCK        8
`define PCS_FLG_TALLY_HI    7

// Configuration register fields
`define PCS_CFG_CONT        0

// Interrupt status and mask fields
`define PCS_IRQ_N           5
`define PCS_IRQ_DONE        0
`define PCS_IRQ_PKT_OV      1
`define PCS_IRQ_BYTE_OV     2
`define PCS_IRQ_TALLY_OV    3
`define PCS_IRQ_WRAP        4

// Reset values
`define PCS_RST_REG         16'h0000
`define PCS_RST_CFG         1'b0
`define PCS_RST_IRQ         5'h00

`endif

// File: core/pcs_counter.v
`timescale 1ns/1ps
`include "pcs_consts.vh"

module pcs_counter #(
    parameter W = 32
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         ce,
    input  wire         rst,
    // Control
    input  wire         inc,
    input  wire         clr,
    input  wire         lock,
    input  wire         contMode,
    // Results
    output wire [W-1:0] count,
    output wire [W-1:0] snap,
    output wire         wrapPulse,
    output wire         ovEvent
);
    reg  [W-1:0] count_q;
    reg  [W-1:0] snap_q;
    reg          wrap_q;
    wire         atMax;

    assign atMax     = &count_q;
    assign ovEvent   = inc & atMax & ~clr;
    assign count     = count_q;
    assign snap      = snap_q;
    assign wrapPulse = wrap_q;

    always @(posedge core_clk) begin
        if (rst) begin
            count_q <= {W{1'b0}};
            snap_q  <= {W{1'b0}};
            wrap_q  <= 1'b0;
        end else if (ce) begin
            // Snapshot takes the value before a same-cycle clear
            if (lock) begin
                snap_q <= count_q;
            end
            if (clr) begin
                count_q <= {{(W-1){1'b0}}, inc};
            end else if (inc) begin
                if (!atMax) begin
                    count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
                end else if (contMode) begin
                    count_q <= {W{1'b0}};
                end
            end
            wrap_q <= ovEvent & contMode;
        end
    end
endmodule

// File: core/pcs_irq.v
`timescale 1ns/1ps
`include "pcs_consts.vh"

module pcs_irq #(
    parameter N = 5
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         ce,
    input  wire         rst,
    // Event inputs, one-cycle pulses
    input  wire [N-1:0] events,
    // Software access
    input  wire         statWr,
    input  wire         maskWr,
    input  wire [N-1:0] wdata,
    // State
    output wire [N-1:0] status,
    output wire [N-1:0] mask,
    output wire         irq
);
    reg [N-1:0] status_q;
    reg [N-1:0] mask_q;
    reg         irq_q;
    reg [N-1:0] status_d;

    assign status = status_q;
    assign mask   = mask_q;
    assign irq    = irq_q;

    // New event wins over a write-one clear in the same cycle
    always @* begin
        status_d = status_q;
        if (statWr) begin
            status_d = status_d & ~wdata;
        end
        status_d = status_d | events;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            status_q <= {N{1'b0}};
            mask_q   <= {N{1'b0}};
            irq_q    <= 1'b0;
        end else if (ce) begin
            status_q <= status_d;
            if (maskWr) begin
                mask_q <= wdata;
            end
            irq_q <= |(status_d & (maskWr ? wdata : mask_q));
        end
    end
endmodule

// File: test/pcs_props.sv
`timescale 1ns/1ps
module pcs_props #(
    parameter AW = 12,
    parameter DW = 16
) (
    // Clock and reset
    input wire          core_clk,
    input wire          ce,
    input wire          rst,
    // Register port
    input wire [AW-1:0] regAddr,
    input wire [DW-1:0] regWdata,
    input wire          regWr,
    input wire          regRd,
    input wire [DW-1:0] regRdata,
    // Checker and generator
    input wire          chkPktRx,
    input wire          chkByteRx,
    input wire          chkByteErr,
    input wire          chkLock,
    input wire          genBusy,
    input wire          genDone,
    input wire          irq,
    input wire          counterWrap
);
    wire rdFlg = regRd && regAddr == 12'h620;
    wire evt   = chkPktRx || chkByteRx || chkByteErr;
    wire clr15 = regWr && regAddr == 12'h01b && regWdata[15];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_rd_idle; $past(ce) && !$past(regRd) |-> regRdata == 16'h0000; endproperty
    property p_rsv; rdFlg |=> regRdata[15:13] == 3'h0; endproperty
    property p_ctrl; regRd && regAddr == 12'h01b |=> regRdata == 16'h0000; endproperty
    property p_busy; $stable(genBusy) && genBusy == $past(genBusy, 2) ##0 rdFlg
        |=> regRdata[11] == $past(genBusy); endproperty
    property p_done; genDone ##1 (!genBusy) [*3] ##0 rdFlg |=> regRdata[12]; endproperty
    property p_rst; $fell(rst) |-> regRdata == 16'h0000 && !irq && !counterWrap; endproperty
    property p_wrap; counterWrap |-> $past(evt) || $past(evt, 2); endproperty
    property p_err_clr; clr15 && !chkByteErr ##1 regRd && regAddr == 12'h622
        |=> regRdata == 16'h0000; endproperty
    property p_ov_clr; clr15 && !chkPktRx && !chkByteRx ##1 rdFlg
        |=> regRdata[10:9] == 2'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_rsv: assert property (p_rsv) else $error("reserved flag bits set");
    a_ctrl: assert property (p_ctrl) else $error("control read not zero");
    a_busy: assert property (p_busy) else $error("busy flag wrong");
    a_done: assert property (p_done) else $error("done flag missing");
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    a_wrap: assert property (p_wrap) else $error("wrap pulse without event");
    a_err_clr: assert property (p_err_clr) else $error("error count not cleared");
    a_ov_clr: assert property (p_ov_clr) else $error("overflow not cleared");
    c_wrap: cover property (counterWrap);
    c_irq: cover property ($rose(irq));
    c_clr: cover property (clr15);
endmodule

bind pcs_top pcs_props #(.AW(AW), .DW(DW)) u_props (
    .core_clk(core_clk), .ce(ce), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .chkPktRx(chkPktRx),
    .chkByteRx(chkByteRx), .chkByteErr(chkByteErr), .chkLock(chkLock),
    .genBusy(genBusy), .genDone(genDone), .irq(irq), .counterWrap(counterWrap));

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        core_clk = 0;
    logic        rst = 1, ce = 1;
    logic        regWr = 0, regRd = 0, rdPend = 0;
    logic        chkPktRx = 0, chkByteRx = 0, chkByteErr = 0;
    logic        chkLock = 0, genBusy = 0, genDone = 0;
    logic [11:0] regAddr = 0;
    logic [15:0] regWdata = 0, exp;
    wire  [15:0] regRdata;
    wire         irq, counterWrap;
    logic [15:0] expQ[$];
    logic [11:0] roAddr[5] = '{12'h61d, 12'h61e, 12'h620, 12'h622, 12'h623};
    int          num_errors = 0, compares = 0, wraps = 0, seed = 47, n;

    always #2.5 core_clk = ~core_clk;

    // Short packet and byte counters so saturation is reachable
    pcs_top #(.PKT_W(4), .BYTE_W(4)) DUT (
        .core_clk(core_clk), .ce(ce), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .chkPktRx(chkPktRx), .chkByteRx(chkByteRx), .chkByteErr(chkByteErr),
        .chkLock(chkLock), .genBusy(genBusy), .genDone(genDone), .irq(irq),
        .counterWrap(counterWrap));

    // One task drives every strobe each cycle, so none is assigned twice
    task automatic cyc(input bit w, r, input logic [11:0] a, input logic [15:0] d,
                       input bit p, b, e, g);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
        chkPktRx <= p;
        chkByteRx <= b;
        chkByteErr <= e;
        genDone <= g;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        cyc(1, 0, a, d, 0, 0, 0, 0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] x);
        expQ.push_back(x);
        cyc(0, 1, a, 16'h0000, 0, 0, 0, 0);
    endtask
    task automatic pulse(input bit p, b, e, g, input int k);
        repeat (k) cyc(0, 0, 12'h000, 16'h0000, p, b, e, g);
        cyc(0, 0, 12'h000, 16'h0000, 0, 0, 0, 0);
    endtask
    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe; looked at mid-cycle
    always @(negedge core_clk) begin
        if (rdPend) begin
            exp = expQ.pop_front();
            compares++;
            if (regRdata !== exp) begin
                num_errors++;
                $display("unexpected at %0t: read %h, wanted %h", $time, regRdata, exp);
            end
        end
        rdPend <= regRd;
        if (counterWrap === 1'b1)
            wraps++;
    end

    initial begin
        #20000;
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        foreach (roAddr[i]) begin
            wr(roAddr[i], 16'($random(seed)));
            rd(roAddr[i], 16'h0000);
        end
        wr(12'h7ff, 16'hffff);
        rd(12'h7ff, 16'h0000);
        rd(12'h01b, 16'h0000);
        n = ($random(seed) & 7) + 1;
        pulse(1, 0, 0, 0, n);
        wr(12'h01b, 16'h4000);
        pulse(1, 0, 0, 0, 3);
        rd(12'h61d, 16'(n));
        rd(12'h61e, 16'h0000);
        // Single mode: packet and byte counters saturate, flags stick
        pulse(1, 1, 1, 0, 20);
        rd(12'h622, 16'd20);
        rd(12'h623, 16'h0000);
        // Enable low must freeze the error counter and tally
        ce <= 1'b0;
        pulse(0, 0, 1, 0, 3);
        ce <= 1'b1;
        rd(12'h622, 16'd20);
        wr(12'h01b, 16'h0001);
        rd(12'h61d, 16'h000f);
        rd(12'h620, 16'h0614);
        wr(12'h01b, 16'h8000);
        rd(12'h622, 16'h0000);
        wr(12'h01b, 16'h8000);
        rd(12'h620, 16'h0000);
        rd(12'h61d, 16'h0000);
        pulse(0, 0, 1, 0, 260);
        rd(12'h622, 16'h0104);
        wr(12'h01b, 16'h0002);
        rd(12'h620, 16'h00ff);
        wr(12'h01b, 16'h0001);
        rd(12'h620, 16'h0000);
        // Continuous mode wraps with one pulse
        wr(12'h630, 16'h0001);
        rd(12'h630, 16'h0001);
        pulse(1, 0, 0, 0, 16);
        wr(12'h01b, 16'h0001);
        rd(12'h61d, 16'h0000);
        chk(wraps == 1, "wrap pulse count");
        wr(12'h631, 16'h001f);
        wr(12'h632, 16'h0000);
        rd(12'h631, 16'h0000);
        pulse(0, 0, 0, 1, 1);
        // Irq is looked at mid-cycle, then the bench realigns to the edge
        @(negedge core_clk);
        chk(irq === 1'b0, "masked irq high");
        @(posedge core_clk);
        rd(12'h620, 16'h1400);
        rd(12'h631, 16'h0001);
        wr(12'h632, 16'h0001);
        rd(12'h632, 16'h0001);
        pulse(0, 0, 0, 0, 0);
        @(negedge core_clk);
        chk(irq === 1'b1, "irq low");
        @(posedge core_clk);
        rd(12'h620, 16'h1400);
        wr(12'h631, 16'h0001);
        pulse(0, 0, 0, 0, 0);
        @(negedge core_clk);
        chk(irq === 1'b0, "irq not cleared");
        @(posedge core_clk);
        genBusy <= 1'b1;
        chkLock <= 1'b1;
        pulse(0, 0, 0, 0, 2);
        rd(12'h620, 16'h0d00);
        pulse(0, 0, 0, 0, 2);
        wrap_up();
    end
endmodule
